// ---- src/ftbs_map.svh ----
// constants for the flow-through burst sram: widths, reset values
`ifndef FTBS_MAP_SVH
`define FTBS_MAP_SVH

`define FTBS_ADDR_W 18
`define FTBS_LANES 2
`define FTBS_LANE_W 8
`define FTBS_BURST_W 2

`define FTBS_RST_OE_N 1'b1
`define FTBS_RST_MODE 1'b1
`define FTBS_RST_DRIVE 1'b0
`define FTBS_RST_WR_PEND 1'b0

`endif

// ---- src/ftbs_pkg.sv ----
// types shared by the flow-through burst sram files
package ftbs_pkg;

	typedef enum logic [1:0] {
		FTBS_OP_IDLE,
		FTBS_OP_READ,
		FTBS_OP_WRITE
	} ftbs_op_type;

endpackage : ftbs_pkg

// ---- src/ftbs_burst_step.sv ----
// burst order sequencer: low address bits for a given burst step
`timescale 1ns/1ps
`include "ftbs_map.svh"
module ftbs_burst_step #(
	parameter int BURST_W = `FTBS_BURST_W
) (
	// burst origin and position
	input wire logic [BURST_W-1:0] start_lo,
	input wire logic [BURST_W-1:0] step,
	input wire logic interleave,
	// resulting low address bits
	output logic [BURST_W-1:0] next_lo
);
	import ftbs_pkg::*;

	if (BURST_W < 1) begin : g_bad_width
		$error("ftbs_burst_step: BURST_W must be at least 1");
	end

	// wraps inside the group of 2**BURST_W words
	always_comb begin
		if (interleave) begin
			next_lo = start_lo ^ step;
		end else begin
			next_lo = BURST_W'(start_lo + step);
		end
	end

endmodule : ftbs_burst_step

// ---- src/ftbs_sram.sv ----
// flow-through burst sram core: registered inputs, lane writes, burst counter
`timescale 1ns/1ps
`include "ftbs_map.svh"
module ftbs_sram #(
	parameter int ADDR_W = `FTBS_ADDR_W,
	parameter int LANES = `FTBS_LANES,
	parameter int LANE_W = `FTBS_LANE_W,
	parameter int BURST_W = `FTBS_BURST_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// synchronous control
	input wire logic clk_qualifier_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic write_strobe_n,
	input wire logic [LANES-1:0] byte_lane_strobe_n,
	input wire logic advance_or_load,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b,
	input wire logic chip_select_c_n,
	// asynchronous enable and static strap
	input wire logic output_enable_n,
	input wire logic burst_mode,
	// data and parity lines, split into in, out and enable
	input wire logic [LANES*LANE_W-1:0] data_in,
	input wire logic [LANES-1:0] parity_in,
	output logic [LANES*LANE_W-1:0] data_out,
	output logic [LANES-1:0] parity_out,
	output logic data_oe
);
	import ftbs_pkg::*;

	localparam int DATA_W = LANES * LANE_W;
	localparam int LANE_WB = LANE_W + 1;
	localparam int WORD_W = LANES * LANE_WB;
	localparam int DEPTH = 2 ** ADDR_W;

	if (ADDR_W <= BURST_W || LANES < 1 || LANE_W < 1 || BURST_W < 1) begin : g_bad_cfg
		$error("ftbs_sram: unsupported width parameters");
	end

	typedef struct packed {
		ftbs_op_type op;
		logic [ADDR_W-1:0] addr;
		logic [BURST_W-1:0] start_lo;
		logic [BURST_W-1:0] count;
		logic wr_pend;
		logic [ADDR_W-1:0] wr_addr;
		logic [LANES-1:0] wr_lanes;
		logic [DATA_W-1:0] dout;
		logic [LANES-1:0] pout;
		logic drive;
		logic oe_n_meta;
		logic oe_n_sync;
		logic mode_meta;
		logic mode_sync;
	} ftbs_state_type;

	ftbs_state_type st_r;
	ftbs_state_type st_nxt;

	// word layout per lane: {parity, data byte}
	logic [WORD_W-1:0] mem [0:DEPTH-1];

	logic selected;
	logic [BURST_W-1:0] count_inc;
	logic [BURST_W-1:0] burst_lo;
	logic [WORD_W-1:0] rd_word;
	logic [ADDR_W-1:0] rd_addr;
	// lane-ordered views of output and bus words, used only by the checks
	logic [WORD_W-1:0] out_word;
	logic [WORD_W-1:0] in_word;
	logic [WORD_W-1:LANE_WB] wr_upper_old;

	assign selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;
	assign count_inc = BURST_W'(st_r.count + 1'b1);

	ftbs_burst_step #(
		.BURST_W(BURST_W)
	) u_burst_step (
		.start_lo(st_r.start_lo),
		.step(count_inc),
		.interleave(st_r.mode_sync),
		.next_lo(burst_lo)
	);

	// read word with forwarding of the write committing on this edge
	always_comb begin
		rd_addr = advance_or_load ? {st_r.addr[ADDR_W-1:BURST_W], burst_lo} : address;
		rd_word = mem[rd_addr];
		for (int i = 0; i < LANES; i++) begin
			if (st_r.wr_pend && st_r.wr_lanes[i] && st_r.wr_addr == rd_addr) begin
				rd_word[i*LANE_WB +: LANE_WB] = {parity_in[i], data_in[i*LANE_W +: LANE_W]};
			end
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.oe_n_meta = output_enable_n;
		st_nxt.oe_n_sync = st_r.oe_n_meta;
		st_nxt.mode_meta = burst_mode;
		st_nxt.mode_sync = st_r.mode_meta;
		if (!clk_qualifier_n) begin
			st_nxt.wr_pend = 1'b0;
			if (advance_or_load) begin
				// continue the previous operation at the next burst address
				st_nxt.count = count_inc;
				st_nxt.addr = {st_r.addr[ADDR_W-1:BURST_W], burst_lo};
			end else if (selected) begin
				st_nxt.op = write_strobe_n ? FTBS_OP_READ : FTBS_OP_WRITE;
				st_nxt.addr = address;
				st_nxt.start_lo = address[BURST_W-1:0];
				st_nxt.count = '0;
			end else begin
				st_nxt.op = FTBS_OP_IDLE;
			end
			if (st_nxt.op == FTBS_OP_WRITE) begin
				st_nxt.wr_pend = 1'b1;
				st_nxt.wr_addr = st_nxt.addr;
				st_nxt.wr_lanes = ~byte_lane_strobe_n;
			end
			if (st_nxt.op == FTBS_OP_READ) begin
				for (int i = 0; i < LANES; i++) begin
					st_nxt.dout[i*LANE_W +: LANE_W] = rd_word[i*LANE_WB +: LANE_W];
					st_nxt.pout[i] = rd_word[i*LANE_WB + LANE_W];
				end
			end
		end
		// enable follows the sampled output enable even through a stall
		st_nxt.drive = (st_nxt.op == FTBS_OP_READ) && !st_r.oe_n_sync;
		if (!reset_n) begin
			st_nxt = '0;
			st_nxt.op = FTBS_OP_IDLE;
			st_nxt.wr_pend = `FTBS_RST_WR_PEND;
			st_nxt.drive = `FTBS_RST_DRIVE;
			st_nxt.oe_n_meta = `FTBS_RST_OE_N;
			st_nxt.oe_n_sync = `FTBS_RST_OE_N;
			st_nxt.mode_meta = `FTBS_RST_MODE;
			st_nxt.mode_sync = `FTBS_RST_MODE;
		end
	end

	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	// self-timed commit of the write data phase, lane by lane
	always_ff @(posedge clk) begin
		if (reset_n && !clk_qualifier_n && st_r.wr_pend) begin
			for (int i = 0; i < LANES; i++) begin
				if (st_r.wr_lanes[i]) begin
					mem[st_r.wr_addr][i*LANE_WB +: LANE_WB] <=
						{parity_in[i], data_in[i*LANE_W +: LANE_W]};
				end
			end
		end
	end

	assign data_out = st_r.dout;
	assign parity_out = st_r.pout;
	assign data_oe = st_r.drive;

	// same {parity, byte} layout as the memory word
	for (genvar g = 0; g < LANES; g++) begin : g_lane_view
		assign out_word[g*LANE_WB +: LANE_WB] = {st_r.pout[g], st_r.dout[g*LANE_W +: LANE_W]};
		assign in_word[g*LANE_WB +: LANE_WB] = {parity_in[g], data_in[g*LANE_W +: LANE_W]};
	end
	// upper lanes of the pending write target, before it commits
	assign wr_upper_old = mem[st_r.wr_addr][WORD_W-1:LANE_WB];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence seq_load;
		!clk_qualifier_n && !advance_or_load;
	endsequence

	sequence seq_wr_cmd0;
		seq_load and (selected && !write_strobe_n && !byte_lane_strobe_n[0]);
	endsequence

	sequence seq_wr_cmd1_off;
		seq_load and (selected && !write_strobe_n && byte_lane_strobe_n[1]);
	endsequence

	sequence seq_data_phase;
		!clk_qualifier_n;
	endsequence

	sequence seq_read_cmd;
		seq_load and (selected && write_strobe_n);
	endsequence

	sequence seq_stall;
		clk_qualifier_n;
	endsequence

	sequence seq_full_write;
		seq_load and (selected && !write_strobe_n && byte_lane_strobe_n == '0);
	endsequence

	sequence seq_same_read;
		seq_read_cmd and (address == $past(address));
	endsequence

	chk_stall_holds_state: assert property (
		clk_qualifier_n |=> $stable(st_r.addr) && $stable(st_r.op) && $stable(data_out))
		else $error("stalled edge changed state");

	chk_load_takes_addr: assert property (
		seq_load and selected |=> st_r.addr == $past(address))
		else $error("loaded address not taken");

	chk_burst_low_bits: assert property (
		!clk_qualifier_n && advance_or_load |=>
			st_r.addr[ADDR_W-1:BURST_W] == $past(st_r.addr[ADDR_W-1:BURST_W]) &&
			st_r.count == BURST_W'($past(st_r.count) + 1'b1))
		else $error("burst step wrong");

	chk_write_hiz: assert property (
		seq_load and (selected && !write_strobe_n) |=> !data_oe)
		else $error("driving during write data phase");

	chk_desel_hiz: assert property (
		seq_load and !selected |=> !data_oe)
		else $error("driving while deselected");

	chk_oe_masks: assert property (
		st_r.oe_n_sync |=> !data_oe)
		else $error("driving with output enable high");

	chk_read_drives: assert property (
		seq_read_cmd and !st_r.oe_n_sync |=> data_oe)
		else $error("read not driven");

	chk_lane0_written: assert property (
		seq_wr_cmd0 ##1 seq_data_phase |=>
			mem[$past(address, 2)][LANE_WB-1:0] == $past({parity_in[0], data_in[LANE_W-1:0]}))
		else $error("lane 0 write lost");

	chk_lane1_masked: assert property (
		seq_wr_cmd1_off ##1 seq_data_phase |=>
			mem[$past(address, 2)][WORD_W-1:LANE_WB] == $past(wr_upper_old))
		else $error("masked lane written");

	chk_turnaround: assert property (
		(seq_load and (selected && !write_strobe_n)) ##1 (seq_read_cmd and !st_r.oe_n_sync)
			|=> data_oe)
		else $error("read after write stalled");

	// reset must hold even though the default disable would mask it
	chk_reset_quiet: assert property (disable iff (1'b0)
		!reset_n |=> !data_oe && st_r.op == FTBS_OP_IDLE && !st_r.wr_pend)
		else $error("reset left an access active");

	chk_read_data: assert property (
		seq_read_cmd and !(st_r.wr_pend && st_r.wr_addr == address)
			|=> out_word == $past(mem[address]))
		else $error("read word differs from memory");

	chk_forward_word: assert property (
		seq_full_write ##1 seq_same_read |=> out_word == $past(in_word))
		else $error("read after write missed the new word");

	chk_stall_no_write: assert property (
		seq_stall and st_r.wr_pend
			|=> st_r.wr_pend && mem[$past(st_r.wr_addr)] == $past(mem[st_r.wr_addr]))
		else $error("stalled edge touched memory");

	chk_stalled_write_hiz: assert property (
		(seq_load and (selected && !write_strobe_n)) ##1 seq_stall |=> !data_oe)
		else $error("driving in a stalled write");

	chk_advance_keeps_op: assert property (
		!clk_qualifier_n && advance_or_load |=> st_r.op == $past(st_r.op))
		else $error("burst step changed the operation");

	chk_desel_clears_op: assert property (
		seq_load and !selected |=> st_r.op == FTBS_OP_IDLE && !st_r.wr_pend)
		else $error("deselect kept an access");

	chk_lane_latch: assert property (
		seq_load and (selected && !write_strobe_n) |=> st_r.wr_lanes == ~$past(byte_lane_strobe_n))
		else $error("lane selects not latched");

endmodule : ftbs_sram

// ---- tb/ftbs_ctrl_model.sv ----
// controller model: drives requests and the shared data lines
`timescale 1ns/1ps
module ftbs_ctrl_model (
	// clock
	input wire logic clk,
	// device outputs
	input wire logic [15:0] data_out,
	input wire logic [1:0] parity_out,
	input wire logic data_oe,
	// requests
	output logic clk_qualifier_n,
	output logic [17:0] address,
	output logic write_strobe_n,
	output logic [1:0] byte_lane_strobe_n,
	output logic advance_or_load,
	output logic chip_select_a_n,
	output logic chip_select_b,
	output logic chip_select_c_n,
	// wire level, parity above data
	output logic [17:0] bus
);
	logic [17:0] wd, last, seen;
	logic de, seen_oe;
	// released lines show the inverse of their last level
	always_comb bus = data_oe ? {parity_out, data_out} : (de ? wd : ~last);
	always @(posedge clk) last <= bus;
	initial begin
		{clk_qualifier_n, write_strobe_n, byte_lane_strobe_n, advance_or_load} = 5'h1f;
		{chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h6;
		address = 18'h0;
		de = 1'b0;
		wd = 18'h0;
		last = 18'h0;
	end
	// one cycle; c is {a_n, b, c_n}, e and d give the data phase word
	task automatic cyc(input logic q, v, w, input logic [1:0] l, input logic [17:0] a,
		input logic [2:0] c, input logic e, input logic [17:0] d);
		@(negedge clk);
		seen = bus;
		seen_oe = data_oe;
		clk_qualifier_n = q;
		advance_or_load = v;
		write_strobe_n = w;
		byte_lane_strobe_n = l;
		address = a;
		{chip_select_a_n, chip_select_b, chip_select_c_n} = c;
		de = e;
		wd = d;
	endtask : cyc
endmodule : ftbs_ctrl_model

// ---- tb/testbench.sv ----
// testbench: scenarios for the flow-through burst sram
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
	$display("BAD %s exp %h seen %h", n, e, s); end end
`define SEEN i_ftbs_ctrl_model.seen
`define OE i_ftbs_ctrl_model.seen_oe
module testbench;
	logic clk, reset_n, burst_mode, data_oe, output_enable_n;
	logic clk_qualifier_n, write_strobe_n, advance_or_load;
	logic chip_select_a_n, chip_select_b, chip_select_c_n;
	logic [17:0] address, bus;
	logic [1:0] byte_lane_strobe_n, parity_out;
	logic [15:0] data_out;
	int mismatches, checks;
	localparam logic [2:0] SEL = 3'h2;
	localparam logic [2:0] TAB [4] = '{3'h6, 3'h0, 3'h3, 3'h2};
	ftbs_sram i_ftbs_sram (.clk(clk), .reset_n(reset_n), .clk_qualifier_n(clk_qualifier_n),
		.address(address), .write_strobe_n(write_strobe_n),
		.byte_lane_strobe_n(byte_lane_strobe_n), .advance_or_load(advance_or_load),
		.chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
		.chip_select_c_n(chip_select_c_n), .output_enable_n(output_enable_n),
		.burst_mode(burst_mode), .data_in(bus[15:0]), .parity_in(bus[17:16]),
		.data_out(data_out), .parity_out(parity_out), .data_oe(data_oe));
	ftbs_ctrl_model i_ftbs_ctrl_model (.clk(clk), .data_out(data_out),
		.parity_out(parity_out), .data_oe(data_oe), .clk_qualifier_n(clk_qualifier_n),
		.address(address), .write_strobe_n(write_strobe_n),
		.byte_lane_strobe_n(byte_lane_strobe_n), .advance_or_load(advance_or_load),
		.chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
		.chip_select_c_n(chip_select_c_n), .bus(bus));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic step(input logic q, v, w, input logic [1:0] l, input logic [17:0] a,
		input logic [2:0] c, input logic e, input logic [17:0] d);
		i_ftbs_ctrl_model.cyc(q, v, w, l, a, c, e, d);
	endtask : step
	task automatic do_reset(input logic m);
		burst_mode = m;
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask : do_reset
	task automatic t_back_to_back;
		step(0, 0, 0, 2'h0, 18'h3ffff, SEL, 0, 0);
		step(0, 0, 0, 2'h0, 18'h00000, SEL, 1, 18'h2a5c3);
		`CHK("oe in write data", 1'b0, `OE)
		step(0, 0, 1, 2'h0, 18'h3ffff, SEL, 1, 18'h15a3c);
		step(0, 0, 1, 2'h0, 18'h00000, SEL, 0, 0);
		`CHK("top word", 18'h2a5c3, `SEEN)
		step(0, 0, 1, 2'h0, 18'h0, 3'h6, 0, 0);
		`CHK("bottom word", 18'h15a3c, `SEEN)
	endtask : t_back_to_back
	task automatic t_lanes;
		step(0, 0, 0, 2'h0, 18'h12345, SEL, 0, 0);
		step(0, 0, 1, 2'h0, 18'h12345, SEL, 1, 18'h3ffff);
		step(0, 0, 0, 2'h2, 18'h12345, SEL, 0, 0);
		`CHK("full word", 18'h3ffff, `SEEN)
		step(0, 0, 1, 2'h2, 18'h12345, SEL, 1, 18'h0);
		step(0, 0, 0, 2'h1, 18'h12345, SEL, 0, 0);
		`CHK("lane 0 word", 18'h2ff00, `SEEN)
		step(0, 0, 1, 2'h1, 18'h12345, SEL, 1, 18'h0);
		step(0, 0, 1, 2'h0, 18'h0, 3'h6, 0, 0);
		`CHK("lane 1 word", 18'h0, `SEEN)
	endtask : t_lanes
	task automatic t_burst;
		for (int m = 1; m >= 0; m--) begin
			do_reset(m[0]);
			for (int i = 0; i < 4; i++)
				step(0, 0, 0, 2'h0, 18'(18'h100 + i), SEL, i > 0, 18'(18'h1f + i));
			step(0, 0, 1, 2'h0, 18'h101, SEL, 1, 18'h23);
			for (int i = 0; i < 4; i++) begin
				step(0, i < 3, 1, 2'h0, 18'h101, i < 3 ? SEL : 3'h6, 0, 0);
				`CHK("burst", 18'h20 + (m ? 2'h1 ^ i[1:0] : 2'(i + 1)), `SEEN)
			end
		end
	endtask : t_burst
	task automatic t_stall;
		step(0, 0, 1, 2'h0, 18'h101, SEL, 0, 0);
		step(1, 0, 1, 2'h0, 18'h100, SEL, 0, 0);
		step(1, 0, 1, 2'h0, 18'h100, SEL, 0, 0);
		`CHK("held", 18'h21, `SEEN)
		step(0, 1, 1, 2'h0, 18'h100, SEL, 0, 0);
		`CHK("held", 18'h21, `SEEN)
		step(0, 0, 1, 2'h0, 18'h0, 3'h6, 0, 0);
		`CHK("after stall", 18'h22, `SEEN)
		step(0, 0, 0, 2'h0, 18'h100, SEL, 0, 0);
		step(1, 0, 1, 2'h0, 18'h0, SEL, 1, 18'h15555);
		step(0, 0, 1, 2'h0, 18'h100, SEL, 1, 18'h2c3a5);
		`CHK("oe in stalled write", 1'b0, `OE)
		step(0, 0, 1, 2'h0, 18'h100, SEL, 0, 0);
		`CHK("forwarded word", 18'h2c3a5, `SEEN)
		step(0, 0, 1, 2'h0, 18'h0, 3'h6, 0, 0);
		`CHK("stored word", 18'h2c3a5, `SEEN)
	endtask : t_stall
	task automatic t_select;
		for (int k = 0; k < 4; k++) begin
			step(0, 0, 1, 2'h0, 18'h101, TAB[k], 0, 0);
			step(0, 0, 1, 2'h0, 18'h0, 3'h6, 0, 0);
			`CHK("drive", 1'(k == 3), `OE)
		end
		output_enable_n = 1'b1;
		repeat (4) step(0, 0, 1, 2'h0, 18'h101, SEL, 0, 0);
		`CHK("oe high", 1'b0, `OE)
		output_enable_n = 1'b0;
	endtask : t_select
	task automatic conclude;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	initial begin
		output_enable_n = 1'b0;
		do_reset(1'b1);
		t_back_to_back;
		t_lanes;
		t_burst;
		t_stall;
		t_select;
		conclude;
	end
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		conclude;
	end
endmodule : testbench
